// ==== core/fsq_pkg.sv ====
// Purpose: constants and types of the flash self-program sequencer
// Assumes: 32-bit classic Wishbone register window, 10 MHz clock
// Notes:   command patterns are compared on bits 4..0 of the control byte; bit 5 is not stored
package fsq_pkg;
   // register byte addresses
   localparam logic [7:0]  ADR_CTRL   = 8'h00;
   localparam logic [7:0]  ADR_PTR    = 8'h04;
   localparam logic [7:0]  ADR_DATA   = 8'h08;
   localparam logic [7:0]  ADR_INSTR  = 8'h0C;
   localparam logic [7:0]  ADR_STAT   = 8'h10;
   // control/status bit positions
   localparam int          CB_EN      = 0;
   localparam int          CB_LOCK    = 3;
   localparam int          CB_BUSY    = 6;
   localparam int          CB_IE      = 7;
   // instruction register bit positions
   localparam int          IB_STORE   = 0;
   localparam int          IB_LOAD    = 1;
   // command patterns on bits 5..0
   localparam logic [5:0]  CMD_LOAD   = 6'h01;
   localparam logic [5:0]  CMD_ERASE  = 6'h03;
   localparam logic [5:0]  CMD_WRITE  = 6'h05;
   localparam logic [5:0]  CMD_LOCK   = 6'h09;
   localparam logic [5:0]  CMD_REEN   = 6'h11;
   localparam logic [5:0]  CMD_NONE   = 6'h00;
   // command windows in clock cycles
   localparam logic [2:0]  STORE_WIN  = 3'h4;
   localparam logic [2:0]  LOAD_WIN   = 3'h3;
   // flash geometry
   localparam int          WORD_W     = 6;
   localparam int          PAGE_W     = 9;
   localparam int          PAGE_WORDS = 64;
   localparam logic [PAGE_W-1:0] HALT_FIRST_PAGE = 9'h1C0;
   localparam logic [15:0] APP_RESET  = 16'h0000;
   localparam logic [15:0] BOOT_START = 16'h1C00;
   localparam logic [15:0] ERASED     = 16'hFFFF;
   // lock and fuse read-back
   localparam logic [5:0]  LOCK_RST   = 6'h3F;
   localparam logic [1:0]  LOCK_TOP   = 2'h3;
   localparam logic [15:0] PTR_FUSE_L = 16'h0000;
   localparam logic [15:0] PTR_LOCK   = 16'h0001;
   localparam logic [15:0] PTR_FUSE_E = 16'h0002;
   localparam logic [15:0] PTR_FUSE_H = 16'h0003;
   localparam logic [7:0]  NOT_FUSE   = 8'hFF;
   // programming time
   localparam int          PROG_NS    = 3700000;
   localparam int          CLK_NS     = 100;
   localparam int          PROG_CYC   = (PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0]  STRAP_WAIT = 2'h3;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_LOCK  = 4'b1000
   } fsq_state_t;

   typedef struct packed {
      logic              erase;
      logic              write;
      logic              lock;
      logic [PAGE_W-1:0] page;
      logic [WORD_W-1:0] widx;
      logic [15:0]       wdata;
   } fsq_flash_op_t;
endpackage : fsq_pkg

// ==== core/fsq_flash_self_program_sequencer.sv ====
// Purpose: self-program sequencer for on-chip program flash
// Assumes: cpu reaches it over classic Wishbone, pins synchronised here
// Notes:   flash array is outside; this block only times and steers it
// Operation
// [R1] boot fuse unprogrammed gives reset 0x0000, programmed gives boot start
// [R2] fuses are inputs only; software cannot change them
// [R3] store commands use pointer: upper bits page, lower bits word
// [R4] target page latched when an operation starts
// [R5] lock-bit setting ignores the pointer completely
// [R6] load reads bytes; pointer bit 0 picks the byte
// [R7] software erases before writing, same page both times
// [R8] buffer accepts word loads in any order
// [R9] store instruction must follow control write within four cycles
// [R10] pattern X0000011 erases the page in the page field
// [R11] pattern 00000001 loads data word at word-in-page index; code ignores bits 7..5, so 10000001 also loads
// [R12] buffer clears after page write, on re-enable, on reset
// [R13] software loads each buffer word at most once per clear
// [R14] eeprom write during buffer loading discards loaded data
// [R15] pattern X0000101 writes buffer to page; other pointer bits zero
// [R16] programming a no-read-while-write page halts the cpu
// [R17] enabled interrupt asserts while self-program enable is clear
// [R18] read-while-write area blocked during any erase or write
// [R19] busy flag holds until re-enable written after completion
// [R20] pattern X0001001 programs lock bits whose data bits are zero
// [R21] lock programming halts nothing and blocks nothing
// [R22] eeprom write blocks store commands and fuse/lock reads
// [R23] software checks eeprom busy before writing control
// [R24] software locks boot area when it never needs updating
// [R25] lock read uses pointer 0x0001 with lock and enable bits
// [R26] load within three cycles returns lock/fuse, then bits clear
// [R27] programmed bits read zero, unprogrammed bits read one
// [R28] enable clears on completion or when the window expires
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_self_program_sequencer
   import fsq_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output      logic [31:0]   wb_dat_o,
   output      logic          wb_ack_o,
   // pins from outside the clock domain
   input  wire logic          boot_reset_select_fuse,
   input  wire logic          eeprom_write_busy,
   input  wire logic [7:0]    fuse_low,
   input  wire logic [7:0]    fuse_high,
   input  wire logic [7:0]    fuse_ext,
   // flash array side
   input  wire logic [15:0]   flash_rdata,
   output      logic [14:0]   flash_raddr,
   output      fsq_flash_op_t flash_op,
   // cpu side
   output      logic [15:0]   reset_vector,
   output      logic          cpu_halt,
   output      logic          rww_read_block,
   output      logic          spm_irq
);

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  lanes);
      merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
                 lanes[0] ? new_v[7:0]  : old_v[7:0]};
   endfunction : merge16

   // true when the page may be programmed while the cpu runs on
   function automatic logic in_rww(input logic [PAGE_W-1:0] page);
      in_rww = page < HALT_FIRST_PAGE;
   endfunction : in_rww

   // [R2] fuse pins read only
   // pin synchronisers; fuses reset to unprogrammed
   logic [25:0] pin_s1_reg;
   logic [25:0] pin_s2_reg;
   logic        eep_d_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_reg <= {2'h2, 24'hFFFFFF};
         pin_s2_reg <= {2'h2, 24'hFFFFFF};
         eep_d_reg  <= 1'b0;
      end else begin
         pin_s1_reg <= {boot_reset_select_fuse, eeprom_write_busy,
                        fuse_low, fuse_high, fuse_ext};
         pin_s2_reg <= pin_s1_reg;
         eep_d_reg  <= pin_s2_reg[24];
      end
   end
   wire        boot_s = pin_s2_reg[25];
   wire        eep_s  = pin_s2_reg[24];
   wire [7:0]  fl_s   = pin_s2_reg[23:16];
   wire [7:0]  fh_s   = pin_s2_reg[15:8];
   wire [7:0]  fe_s   = pin_s2_reg[7:0];

   // state
   fsq_state_t          state_reg;
   logic [4:0]          cmd_reg;
   logic                ie_reg;
   logic                busy_reg;
   logic                halt_reg;
   logic                irq_reg;
   logic [2:0]          store_win_reg;
   logic [2:0]          load_win_reg;
   logic [15:0]         ptr_reg;
   logic [15:0]         data_reg;
   logic [15:0]         timer_reg;
   logic [5:0]          lock_reg;
   logic [5:0]          lock_new_reg;
   logic [7:0]          lpm_res_reg;
   logic [1:0]          strap_cnt_reg;
   logic [15:0]         vec_reg;
   logic                ack_reg;
   logic [31:0]         dat_reg;
   fsq_flash_op_t       op_reg;
   logic [PAGE_WORDS-1:0] pvalid_reg;
   logic [15:0]         pbuf_reg [PAGE_WORDS];

   // bus decode
   wire        req      = wb_cyc_i & wb_stb_i;
   wire        wr       = req & wb_we_i & ack_reg;
   wire        wr_ctrl  = wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0];
   wire        wr_ptr   = wr & (wb_adr_i == ADR_PTR);
   wire        wr_data  = wr & (wb_adr_i == ADR_DATA);
   wire        wr_instr = wr & (wb_adr_i == ADR_INSTR) & wb_sel_i[0];
   wire        idle     = state_reg == ST_IDLE;
   // [R9] four-cycle store window
   wire        store_go = wr_instr & wb_dat_i[IB_STORE] & (store_win_reg != 3'h0);
   // [R22] eeprom blocks store
   wire        spm_ok   = store_go & idle & ~eep_s;
   wire [5:0]  cmd6     = {1'b0, cmd_reg};
   wire        do_load  = spm_ok & (cmd6 == CMD_LOAD);
   wire        do_erase = spm_ok & (cmd6 == CMD_ERASE);
   wire        do_write = spm_ok & (cmd6 == CMD_WRITE);
   wire        do_lock  = spm_ok & (cmd6 == CMD_LOCK);
   wire        do_reen  = spm_ok & (cmd6 == CMD_REEN);
   wire        last     = ~idle & (timer_reg == 16'h0001);
   // a control write landing as the old window runs out keeps its new command
   wire        expire   = idle & (store_win_reg == 3'h1) & ~store_go & ~wr_ctrl;
   // [R26] lock/fuse read window
   wire        load_go  = wr_instr & wb_dat_i[IB_LOAD];
   wire        fuse_rd  = load_go & (load_win_reg != 3'h0) & cmd_reg[CB_EN]
                          & cmd_reg[CB_LOCK] & ~eep_s;
   // [R14] eeprom start loses buffer
   wire        eep_rise = eep_s & ~eep_d_reg;
   // [R12] buffer clear sources
   wire        buf_clr  = do_reen | (last & (state_reg == ST_WRITE)) | eep_rise;
   // [R3] word and page fields
   wire [WORD_W-1:0] ptr_word = ptr_reg[WORD_W:1];
   wire [PAGE_W-1:0] ptr_page = ptr_reg[15:WORD_W+1];

   // [R27] programmed reads zero
   logic [7:0] fuse_val;
   always_comb begin
      unique case (ptr_reg)
         PTR_FUSE_L: fuse_val = fl_s;
         PTR_LOCK:   fuse_val = {LOCK_TOP, lock_reg};
         PTR_FUSE_E: fuse_val = fe_s;
         PTR_FUSE_H: fuse_val = fh_s;
         default:    fuse_val = NOT_FUSE;
      endcase
   end
   // [R6] byte select by bit 0
   wire [7:0]  flash_byte = ptr_reg[0] ? flash_rdata[15:8] : flash_rdata[7:0];

   wire [31:0] rd_ctrl  = {24'h0, ie_reg, busy_reg, 1'b0, cmd_reg};
   wire [31:0] rd_stat  = {18'h0, lock_reg, 4'h0, boot_s, eep_s, halt_reg, ~idle};
   wire [31:0] rd_mux   = (wb_adr_i == ADR_CTRL)  ? rd_ctrl :
                          (wb_adr_i == ADR_PTR)   ? {16'h0, ptr_reg} :
                          (wb_adr_i == ADR_DATA)  ? {16'h0, data_reg} :
                          (wb_adr_i == ADR_INSTR) ? {24'h0, lpm_res_reg} :
                          (wb_adr_i == ADR_STAT)  ? rd_stat : 32'h0;

   // bus slave: ack one cycle after the request, dropped the next cycle
   // the extra cycle gives the read mux a full period; costs one wait state
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (req & ~ack_reg) begin
            dat_reg <= rd_mux;
         end
      end
   end

   // flops rather than a memory, so every word clears in the same cycle
   // [R8] any word order
   generate
      for (genvar gi = 0; gi < PAGE_WORDS; gi++) begin : g_pbuf
         always_ff @(posedge clk) begin
            if (rst | buf_clr) begin
               pvalid_reg[gi] <= 1'b0;
               pbuf_reg[gi]   <= ERASED;
            // [R11] load data word
            end else if (do_load & (ptr_word == WORD_W'(gi))) begin
               pvalid_reg[gi] <= 1'b1;
               pbuf_reg[gi]   <= data_reg;
            end
         end
      end
   endgenerate

   // taken once after the synchroniser settles; a later fuse change waits for reset
   // [R1] reset vector from strap
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_cnt_reg <= 2'h0;
         vec_reg       <= APP_RESET;
      end else if (strap_cnt_reg != STRAP_WAIT) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         vec_reg       <= boot_s ? APP_RESET : BOOT_START;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_reg  <= 16'h0;
         data_reg <= 16'h0;
      end else begin
         if (wr_ptr) begin
            ptr_reg <= merge16(ptr_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
         if (wr_data) begin
            data_reg <= merge16(data_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
      end
   end

   // sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg     <= ST_IDLE;
         cmd_reg       <= 5'h0;
         ie_reg        <= 1'b0;
         store_win_reg <= 3'h0;
         load_win_reg  <= 3'h0;
         timer_reg     <= 16'h0;
         lock_reg      <= LOCK_RST;
         lock_new_reg  <= LOCK_RST;
         op_reg        <= '0;
      end else begin
         store_win_reg <= (store_win_reg != 3'h0) ? store_win_reg - 3'h1 : 3'h0;
         load_win_reg  <= (load_win_reg != 3'h0) ? load_win_reg - 3'h1 : 3'h0;
         // while an operation runs a control write only updates the interrupt enable
         if (wr_ctrl) begin
            ie_reg <= wb_dat_i[CB_IE];
            if (idle) begin
               cmd_reg       <= wb_dat_i[4:0];
               store_win_reg <= wb_dat_i[CB_EN] ? STORE_WIN : 3'h0;
               load_win_reg  <= (wb_dat_i[CB_EN] & wb_dat_i[CB_LOCK]) ? LOAD_WIN : 3'h0;
            end
         end
         // [R28] window expiry clears
         if (expire | (store_go & idle & eep_s)) begin
            cmd_reg <= 5'h0;
         end
         if (do_load | do_reen | (spm_ok & ~do_erase & ~do_write & ~do_lock)) begin
            cmd_reg <= 5'h0;
         end
         // [R10] page erase or page write start
         if (do_erase | do_write) begin
            state_reg     <= do_erase ? ST_ERASE : ST_WRITE;
            timer_reg     <= 16'(PROG_CYCLES);
            // [R4] page latched here
            op_reg.page   <= ptr_page;
            op_reg.erase  <= do_erase;
            op_reg.write  <= do_write;
            op_reg.widx   <= '0;
            store_win_reg <= 3'h0;
         end
         // [R5] pointer not used
         if (do_lock) begin
            state_reg     <= ST_LOCK;
            timer_reg     <= 16'(PROG_CYCLES);
            // [R20] zero bits program
            lock_new_reg  <= lock_reg & data_reg[5:0];
            op_reg.lock   <= 1'b1;
            store_win_reg <= 3'h0;
         end
         if (~idle) begin
            timer_reg <= timer_reg - 16'h1;
         end
         // [R15] page write streams buffer
         if (state_reg == ST_WRITE) begin
            op_reg.widx  <= op_reg.widx + WORD_W'(1);
            op_reg.wdata <= pvalid_reg[op_reg.widx] ? pbuf_reg[op_reg.widx] : ERASED;
         end
         // [R28] completion clears
         if (last) begin
            state_reg    <= ST_IDLE;
            cmd_reg      <= 5'h0;
            op_reg.erase <= 1'b0;
            op_reg.write <= 1'b0;
            op_reg.lock  <= 1'b0;
            if (state_reg == ST_LOCK) begin
               lock_reg <= lock_new_reg;
            end
         end
         // [R26] read-back closes window
         if (fuse_rd) begin
            cmd_reg[CB_EN]   <= 1'b0;
            cmd_reg[CB_LOCK] <= 1'b0;
            load_win_reg     <= 3'h0;
            store_win_reg    <= 3'h0;
         end
      end
   end

   // [R18] rww area blocked
   // [R19] set wins; re-enable clears
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
      end else if (do_erase | do_write) begin
         busy_reg <= 1'b1;
      end else if (do_reen) begin
         busy_reg <= 1'b0;
      end
   end

   // [R16] halt for protected page
   // [R21] lock never halts
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_reg <= 1'b0;
      end else if (do_erase | do_write) begin
         halt_reg <= ~in_rww(ptr_page);
      end else if (do_lock | last) begin
         halt_reg <= 1'b0;
      end
   end

   // [R26] lock/fuse read-back
   // [R6] byte by bit 0
   always_ff @(posedge clk) begin
      if (rst) begin
         lpm_res_reg <= 8'h0;
      end else if (load_go) begin
         lpm_res_reg <= fuse_rd ? fuse_val : flash_byte;
      end
   end

   // level, not a pulse: it stays up until software starts a new command
   // [R17] level interrupt
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= ie_reg & ~cmd_reg[CB_EN];
      end
   end

   assign wb_dat_o       = dat_reg;
   assign wb_ack_o       = ack_reg;
   assign flash_raddr    = ptr_reg[15:1];
   assign flash_op       = op_reg;
   assign reset_vector   = vec_reg;
   assign cpu_halt       = halt_reg;
   assign rww_read_block = busy_reg;
   assign spm_irq        = irq_reg;

endmodule : fsq_flash_self_program_sequencer
`default_nettype wire

// ==== sim/fsq_seq_props.sv ====
// Purpose: port-level assertions for the flash self-program sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   control bits are internal, so rules are tied to port effects
`timescale 1ns/1ps
`default_nettype none
module fsq_seq_props
   import fsq_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // bus
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic          wb_ack_o,
   // pins
   input  wire logic          boot_reset_select_fuse,
   input  wire logic          eeprom_write_busy,
   // outputs
   input  wire fsq_flash_op_t flash_op,
   input  wire logic [15:0]   reset_vector,
   input  wire logic          cpu_halt,
   input  wire logic          rww_read_block
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire         prog     = flash_op.erase | flash_op.write;
   wire         any_op   = prog | flash_op.lock;
   wire         wr_instr = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == ADR_INSTR);
   logic [31:0] run_cnt;
   // length of the running operation, zero while idle
   always_ff @(posedge clk) begin
      if (rst || !any_op) run_cnt <= 32'h0;
      else run_cnt <= run_cnt + 32'h1;
   end
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   boot_vector_a: assert property ($stable(boot_reset_select_fuse)[*5] |->
      reset_vector == (boot_reset_select_fuse ? APP_RESET : BOOT_START))
      else $error("reset vector does not follow boot fuse");
   page_latch_a: assert property (prog && $past(prog) |-> $stable(flash_op.page))
      else $error("target page moved during operation");
   halt_cause_a: assert property (cpu_halt |-> (prog && flash_op.page >= HALT_FIRST_PAGE) ||
      ($past(prog) && $past(flash_op.page) >= HALT_FIRST_PAGE))
      else $error("cpu halted without protected page programming");
   protect_halt_a: assert property (prog && flash_op.page >= HALT_FIRST_PAGE |-> ##[0:1] cpu_halt)
      else $error("cpu not halted for protected page");
   rww_set_a: assert property ($rose(prog) |-> ##[0:1] rww_read_block)
      else $error("read area not blocked at program start");
   rww_keep_a: assert property (rww_read_block && prog |=> rww_read_block)
      else $error("busy flag dropped during operation");
   rww_clear_a: assert property ($fell(rww_read_block) |-> $past(wr_instr) || $past(wr_instr, 2))
      else $error("busy flag cleared without instruction write");
   lock_free_a: assert property (flash_op.lock |-> !cpu_halt)
      else $error("cpu halted during lock programming");
   op_time_a: assert property ($fell(any_op) |-> run_cnt >= PROG_CYCLES - 1 &&
      run_cnt <= PROG_CYCLES + 1)
      else $error("operation length differs from programming time");
   ee_block_a: assert property (eeprom_write_busy[*5] |-> !$rose(any_op))
      else $error("operation started during eeprom write");
   cover property ($rose(flash_op.erase));
   cover property ($rose(flash_op.write));
   cover property ($rose(flash_op.lock));
   cover property ($rose(cpu_halt));
endmodule : fsq_seq_props
bind fsq_flash_self_program_sequencer fsq_seq_props #(.PROG_CYCLES(PROG_CYCLES)) u_fsq_seq_props (
   .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .boot_reset_select_fuse,
   .eeprom_write_busy, .flash_op, .reset_vector, .cpu_halt, .rww_read_block);
`default_nettype wire

// ==== sim/fsq_flash_model.sv ====
// Purpose: behavioural program flash array facing the sequencer
// Assumes: write stream gives one word per cycle, data one cycle after index
// Notes:   power-up content is zero so erase and write effects are visible
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_model
   import fsq_pkg::*;
(
   // clock
   input  wire logic          clk,
   // sequencer side
   input  wire fsq_flash_op_t flash_op,
   input  wire logic [14:0]   flash_raddr,
   output      logic [15:0]   flash_rdata
);
   logic [15:0]       mem [0:32767];
   logic              wr_q;
   logic [WORD_W-1:0] widx_q;
   logic [PAGE_W-1:0] page_q;
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
      wr_q = 1'b0;
   end
   assign flash_rdata = mem[flash_raddr];
   // page is kept a cycle so the late last word still lands in it
   always @(posedge clk) begin
      if (flash_op.erase) begin
         for (int i = 0; i < PAGE_WORDS; i++) mem[{flash_op.page, i[WORD_W-1:0]}] = ERASED;
      end
      if (wr_q) mem[{page_q, widx_q}] = flash_op.wdata;
      wr_q = flash_op.write;
      widx_q = flash_op.widx;
      page_q = flash_op.page;
   end
endmodule : fsq_flash_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: classic Wishbone master tasks, shortened programming time
// Notes:   expected values come from the bench's own tables
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fsq_pkg::*;
   localparam logic [8:0] PG = 9'h010;
   logic          clk, rst, cyc, stb, we, fuse, ee, ack, halt, blk, irq;
   logic [7:0]    adr;
   logic [31:0]   wdat, rdat, d;
   logic [15:0]   rvec, rdata;
   logic [14:0]   raddr;
   fsq_flash_op_t op;
   int            bad_count, num_checks;
   fsq_flash_self_program_sequencer #(.PROG_CYCLES(80)) u_fsq_flash_self_program_sequencer (
      .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .boot_reset_select_fuse(fuse), .eeprom_write_busy(ee), .fuse_low(8'hA5),
      .fuse_high(8'h5A), .fuse_ext(8'hC3), .flash_rdata(rdata), .flash_raddr(raddr),
      .flash_op(op), .reset_vector(rvec), .cpu_halt(halt), .rww_read_block(blk), .spm_irq(irq));
   fsq_flash_model u_fsq_flash_model (.clk(clk), .flash_op(op), .flash_raddr(raddr), .flash_rdata(rdata));
   always #50 clk = ~clk;
   task automatic conclude();
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask : chk
   // one classic cycle; ack waited for under a bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= v;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         bad_count++;
         conclude();
      end
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      wb(1'b1, a, v, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      wb(1'b0, a, 32'h0, r);
   endtask : rd
   // interrupt enable kept set in every command
   task automatic spm(input logic [5:0] c);
      wr(ADR_CTRL, {24'h0, 2'b10, c});
      wr(ADR_INSTR, 32'h1);
   endtask : spm
   task automatic done();
      int n;
      n = 0;
      do begin
         rd(ADR_STAT, d);
         n++;
      end while (d[0] !== 1'b0 && n < 100);
      if (d[0] !== 1'b0) begin
         bad_count++;
         conclude();
      end
   endtask : done
   // byte read; optional lock/enable set just before, inside the load window
   task automatic ldb(input logic [15:0] p, input logic c, input logic [7:0] e);
      wr(ADR_PTR, {16'h0, p});
      if (c) wr(ADR_CTRL, 32'h89);
      wr(ADR_INSTR, 32'h2);
      rd(ADR_INSTR, d);
      chk({24'h0, d[7:0]}, {24'h0, e});
   endtask : ldb
   logic [5:0]  wl [3] = '{6'd5, 6'd63, 6'd0};
   logic [15:0] rb [5] = '{{PG, 7'h0A}, {PG, 7'h0B}, {PG, 7'h7F}, {PG, 7'h00}, {PG, 7'h02}};
   logic [7:0]  re [5] = '{8'h05, 8'hA0, 8'hA0, 8'h00, 8'hFF};
   logic [7:0]  fz [4] = '{8'hA5, 8'hF2, 8'hC3, 8'h5A};
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      fuse = 1'b0;
      ee = 1'b0;
      bad_count = 0;
      num_checks = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      chk({16'h0, rvec}, {16'h0, BOOT_START});
      wr(ADR_STAT, 32'hFFFF_FFFF);
      rd(ADR_STAT, d);
      chk({31'h0, d[3]}, 32'h0);
      rd(8'h20, d);
      chk(d, 32'h0);
      wr(ADR_CTRL, 32'h80);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      foreach (wl[i]) begin
         wr(ADR_PTR, {16'h0, PG, wl[i], 1'b0});
         wr(ADR_DATA, 32'hA000 + wl[i]);
         spm(CMD_LOAD);
      end
      wr(ADR_PTR, {16'h0, PG, 7'h2B});
      spm(CMD_ERASE);
      wr(ADR_PTR, 32'hFFFE);
      chk({29'h0, blk, halt, irq}, 32'h4);
      done();
      chk({30'h0, blk, irq}, 32'h3);
      wr(ADR_PTR, {16'h0, PG, 7'h00});
      spm(CMD_WRITE);
      done();
      chk({31'h0, blk}, 32'h1);
      spm(CMD_REEN);
      repeat (2) @(posedge clk);
      chk({31'h0, blk}, 32'h0);
      foreach (rb[i]) ldb(rb[i], 1'b0, re[i]);
      wr(ADR_PTR, {16'h0, PG, 7'h04});
      wr(ADR_DATA, 32'h1234);
      spm(CMD_LOAD);
      ee <= 1'b1;
      repeat (4) @(posedge clk);
      rd(ADR_STAT, d);
      chk({31'h0, d[2]}, 32'h1);
      spm(CMD_ERASE);
      rd(ADR_STAT, d);
      chk({31'h0, d[0]}, 32'h0);
      ee <= 1'b0;
      repeat (4) @(posedge clk);
      wr(ADR_PTR, {16'h0, PG, 7'h00});
      spm(CMD_ERASE);
      done();
      spm(CMD_WRITE);
      done();
      spm(CMD_REEN);
      ldb({PG, 7'h04}, 1'b0, 8'hFF);
      wr(ADR_PTR, {16'h0, HALT_FIRST_PAGE, 7'h00});
      spm(CMD_ERASE);
      @(posedge clk);
      chk({31'h0, halt}, 32'h1);
      done();
      spm(CMD_REEN);
      wr(ADR_DATA, 32'hF2);
      wr(ADR_PTR, 32'h1234);
      spm(CMD_LOCK);
      @(posedge clk);
      chk({30'h0, halt, blk}, 32'h0);
      done();
      rd(ADR_STAT, d);
      chk({26'h0, d[13:8]}, 32'h32);
      for (int i = 0; i < 4; i++) ldb(i[15:0], 1'b1, fz[i]);
      wr(ADR_PTR, 32'h0);
      wr(ADR_CTRL, 32'h89);
      repeat (5) @(posedge clk);
      ldb(16'h0000, 1'b0, 8'h00);
      rd(ADR_CTRL, d);
      chk(d & 32'h09, 32'h0);
      wr(ADR_CTRL, 32'h83);
      repeat (6) @(posedge clk);
      wr(ADR_INSTR, 32'h1);
      rd(ADR_STAT, d);
      chk({31'h0, d[0]}, 32'h0);
      conclude();
   end
endmodule : testbench
`default_nettype wire
